// file: src/sba_pkg.sv
// Constants, register map and shared types of the sigma background alarm
package sba_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SECOND_S = 1;
  localparam int unsigned SEC_CYCLES_DEF = SECOND_S * CLK_HZ;
  localparam int unsigned BEEP_HALF_MS = 50;
  localparam int unsigned BEEP_HALF_DEF = BEEP_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned FILTER_TC_S = 20;
  localparam logic [5:0] SETTLE_S = 6'd60;
  localparam logic [3:0] LOSS_S = 4'd15;

  // ==========================================================
  // Number formats
  localparam int unsigned RATE_W = 16;
  localparam int unsigned FRAC_W = 8;
  localparam int unsigned BKG_W = RATE_W + FRAC_W;
  localparam logic [7:0] SIGMA_SCALE = 8'd10;
  localparam logic [2:0] SQRT_TOP_BIT = 3'd7;

  // ==========================================================
  // Register map (byte addresses)
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_SIGMA = 12'h004;
  localparam logic [11:0] OFS_CEIL = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_RATE = 12'h010;
  localparam logic [11:0] OFS_BKG = 12'h014;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFS_IRQ_EN = 12'h01C;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h020;
  localparam logic [11:0] OFS_ACK = 12'h024;

  // Field positions and reset values
  localparam int unsigned CTRL_LATCH_BIT = 0;
  localparam int unsigned ACK_BIT = 0;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_SIGMA_BIT = 0;
  localparam int unsigned IRQ_CEIL_BIT = 1;
  localparam int unsigned IRQ_LOSS_BIT = 2;
  localparam logic [7:0] SIGMA_RST = 8'h1E;
  localparam logic [15:0] CEIL_RST = 16'h03E8;

  typedef struct packed {
    logic settled;
    logic det_loss;
    logic ceil_alarm;
    logic sigma_alarm;
  } sba_status_t;

  typedef enum logic [2:0] {
    SBA_IDLE = 3'b001,
    SBA_SQRT = 3'b010,
    SBA_CMP = 3'b100
  } sba_state_t;

endpackage

// file: src/sba_top.sv
// Sigma background alarm: pulse counting, filtering, alarms and APB slave
`timescale 1ns/1ns
// Behaviour
// - Floating limit is background plus sigma times square root of background.
// - Background estimate keeps updating every second while running.
// - Present rate is compared with the floating limit once per second.
// - Sigma multiplier is the software-set sigma register value in tenths.
// - Floating-limit trip starts fast beeping and lights the high indicator.
// - Fixed ceiling trips whenever rate exceeds stored ceiling, background aside.
// - Background uses a twenty-second time constant filter; displayed rate is the raw one-second count.
// - Floating-limit alarm held off for sixty seconds after reset.
// - Low alarm indicator is never driven active.
// - Both alarms drive the single high alarm indicator.
// - Detector loss indicated after fifteen seconds without any pulse.
// - Ceiling alarm clears itself when rate falls, unless latching is set.
module sba_top
  import sba_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF,
  parameter int unsigned BEEP_HALF = BEEP_HALF_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic det_pulse,
  output logic high_alarm_indicator,
  output logic low_alarm_indicator,
  output logic beeper,
  output logic detector_loss_indicator,
  output logic irq
);

  localparam logic [23:0] SEC_LAST = 24'(SEC_CYCLES - 1);
  localparam logic [19:0] BEEP_LAST = 20'(BEEP_HALF - 1);
  localparam logic [31:0] TC = 32'(FILTER_TC_S);

  // ==========================================================
  // Declarations
  logic pulse_d, pulse_edge, tick, seen, settled;
  logic sigma_alarm, ceil_alarm, sigma_hit, ceil_hit, latch_en;
  logic sigma_d, ceil_d, loss_d, setup, wr_en, ack, mapped;
  logic [23:0] sec_cnt;
  logic [RATE_W-1:0] count_acc, present_rate, sq_in, ceiling;
  logic [BKG_W-1:0] background_rate;
  logic [7:0] root, trial, sigma_mult;
  logic [2:0] bitn;
  logic [15:0] trial_sq;
  logic [16:0] thresh;
  logic [31:0] next_bkg, rd_data;
  sba_state_t state;
  logic [5:0] settle_secs;
  logic [3:0] quiet_secs;
  logic [IRQ_W-1:0] irq_stat, irq_en, irq_ev, irq_clr;
  logic [19:0] beep_cnt;
  sba_status_t status;
  assign pulse_edge = det_pulse & ~pulse_d;

  // ==========================================================
  // One-second timebase and pulse counting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sec_cnt <= 24'h000000;
      tick <= 1'b0;
      pulse_d <= 1'b0;
    end
    else
    begin
      pulse_d <= det_pulse;
      tick <= (sec_cnt == SEC_LAST);
      sec_cnt <= (sec_cnt == SEC_LAST) ? 24'h000000 : sec_cnt + 24'h000001;
    end
  end

  // Counter saturates so a huge field cannot wrap to a low rate
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_acc <= 16'h0000;
    else if (tick)
      count_acc <= {15'h0000, pulse_edge};
    else if (pulse_edge && count_acc != 16'hFFFF)
      count_acc <= count_acc + 16'h0001;
  end

  // ==========================================================
  // Square root, threshold and filter arithmetic
  always_comb
  begin
    trial = root | (8'h01 << bitn);
    trial_sq = 16'(trial * trial);
    thresh = {1'b0, background_rate[BKG_W-1:FRAC_W]}
      + 17'(32'(sigma_mult * root) / 32'(SIGMA_SCALE));
    sigma_hit = {1'b0, present_rate} > thresh;
    ceil_hit = present_rate > ceiling;
    // Exponential filter, one step per second
    next_bkg = (32'(background_rate) * (TC - 32'd1)
      + {8'h00, present_rate, 8'h00}) / TC;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= SBA_IDLE;
      present_rate <= 16'h0000;
      sq_in <= 16'h0000;
      root <= 8'h00;
      bitn <= 3'h0;
      background_rate <= 24'h000000;
    end
    else
    begin
      unique case (state)
        SBA_IDLE:
          if (tick)
          begin
            present_rate <= count_acc;
            sq_in <= background_rate[BKG_W-1:FRAC_W];
            root <= 8'h00;
            bitn <= SQRT_TOP_BIT;
            state <= SBA_SQRT;
          end
        SBA_SQRT:
        begin
          if (trial_sq <= sq_in)
            root <= trial;
          if (bitn == 3'h0)
            state <= SBA_CMP;
          else
            bitn <= bitn - 3'h1;
        end
        SBA_CMP:
        begin
          background_rate <= next_bkg[BKG_W-1:0];
          state <= SBA_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Settling, alarms and detector loss
  assign settled = (settle_secs == SETTLE_S);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      settle_secs <= 6'h00;
    else if (state == SBA_CMP && !settled)
      settle_secs <= settle_secs + 6'h01;
  end

  // Compare wins over acknowledge: a trip still present re-arms at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sigma_alarm <= 1'b0;
      ceil_alarm <= 1'b0;
    end
    else if (state == SBA_CMP)
    begin
      sigma_alarm <= (settled && sigma_hit)
        || (latch_en && sigma_alarm && !ack);
      ceil_alarm <= ceil_hit
        || (latch_en && ceil_alarm && !ack);
    end
    else if (ack)
    begin
      sigma_alarm <= 1'b0;
      ceil_alarm <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seen <= 1'b0;
      quiet_secs <= 4'h0;
      detector_loss_indicator <= 1'b0;
    end
    else
    begin
      if (pulse_edge)
        seen <= 1'b1;
      else if (state == SBA_CMP)
        seen <= 1'b0;
      if (pulse_edge)
      begin
        quiet_secs <= 4'h0;
        detector_loss_indicator <= 1'b0;
      end
      else if (state == SBA_CMP)
      begin
        if (seen)
          quiet_secs <= 4'h0;
        else if (quiet_secs != LOSS_S)
          quiet_secs <= quiet_secs + 4'h1;
        if (!seen && quiet_secs >= LOSS_S - 4'h1)
          detector_loss_indicator <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Indicators and beeper
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      high_alarm_indicator <= 1'b0;
      low_alarm_indicator <= 1'b0;
      beeper <= 1'b0;
      beep_cnt <= 20'h00000;
    end
    else
    begin
      high_alarm_indicator <= sigma_alarm | ceil_alarm;
      low_alarm_indicator <= 1'b0;
      if (!(sigma_alarm | ceil_alarm))
      begin
        beeper <= 1'b0;
        beep_cnt <= 20'h00000;
      end
      else if (beep_cnt == BEEP_LAST)
      begin
        beeper <= ~beeper;
        beep_cnt <= 20'h00000;
      end
      else
        beep_cnt <= beep_cnt + 20'h00001;
    end
  end

  // ==========================================================
  // Interrupts
  assign irq_ev = {detector_loss_indicator & ~loss_d,
    ceil_alarm & ~ceil_d, sigma_alarm & ~sigma_d};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sigma_d <= 1'b0;
      ceil_d <= 1'b0;
      loss_d <= 1'b0;
      irq_stat <= 3'h0;
      irq <= 1'b0;
    end
    else
    begin
      sigma_d <= sigma_alarm;
      ceil_d <= ceil_alarm;
      loss_d <= detector_loss_indicator;
      // Set wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      irq <= |(irq_stat & irq_en);
    end
  end

  // ==========================================================
  // APB slave, zero wait states on every transfer
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready & pwrite;
  assign ack = wr_en && paddr == OFS_ACK && pwdata[ACK_BIT];
  assign irq_clr = (wr_en && paddr == OFS_IRQ_CLR) ? pwdata[IRQ_W-1:0] : 3'h0;

  always_comb
  begin
    status.settled = settled;
    status.det_loss = detector_loss_indicator;
    status.ceil_alarm = ceil_alarm;
    status.sigma_alarm = sigma_alarm;
    mapped = 1'b1;
    rd_data = 32'h00000000;
    case (paddr)
      OFS_CTRL: rd_data = {31'h00000000, latch_en};
      OFS_SIGMA: rd_data = {24'h000000, sigma_mult};
      OFS_CEIL: rd_data = {16'h0000, ceiling};
      OFS_STATUS: rd_data = {28'h0000000, status};
      OFS_RATE: rd_data = {16'h0000, present_rate};
      OFS_BKG: rd_data = {8'h00, background_rate};
      OFS_IRQ_STAT: rd_data = {29'h00000000, irq_stat};
      OFS_IRQ_EN: rd_data = {29'h00000000, irq_en};
      OFS_IRQ_CLR: rd_data = 32'h00000000;
      OFS_ACK: rd_data = 32'h00000000;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup && !pwrite) ? rd_data : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      latch_en <= 1'b0;
      sigma_mult <= SIGMA_RST;
      ceiling <= CEIL_RST;
      irq_en <= 3'h0;
    end
    else if (wr_en)
    begin
      case (paddr)
        OFS_CTRL: latch_en <= pwdata[CTRL_LATCH_BIT];
        OFS_SIGMA: sigma_mult <= pwdata[7:0];
        OFS_CEIL: ceiling <= pwdata[RATE_W-1:0];
        OFS_IRQ_EN: irq_en <= pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end
endmodule

// file: tb/sba_det_model.sv
// Detector pulse stream feeding the alarm block
`timescale 1ns/1ns
// ==========================================
// Pulse source
module sba_det_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] gap,
  output logic det_pulse
);
  logic [3:0] cnt;
  // One-cycle pulse every gap cycles; gap 0 stops the stream
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 4'h0;
      det_pulse <= 1'b0;
    end
    else
    begin
      cnt <= (cnt + 4'h1 >= gap) ? 4'h0 : cnt + 4'h1;
      det_pulse <= (gap != 4'h0) && (cnt == 4'h0);
    end
  end
endmodule

// file: tb/sba_top_assertions.sv
// Port checker of the sigma background alarm
`timescale 1ns/1ns
// ==========================================
// Checker
module sba_top_assertions
#(
  parameter int unsigned BEEP_HALF = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic det_pulse,
  input wire logic high_alarm_indicator,
  input wire logic low_alarm_indicator,
  input wire logic beeper,
  input wire logic detector_loss_indicator,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_low_never: assert property (!low_alarm_indicator)
    else $error("low indicator driven");
  a_ready_after: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_beep_quiet: assert property (
    !high_alarm_indicator [*2] |-> !beeper)
    else $error("beeper without alarm");
  // Beeper may rest low one half period at most while an alarm shows
  logic [31:0] mute_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mute_cnt <= 32'h00000000;
    else if (!high_alarm_indicator || beeper)
      mute_cnt <= 32'h00000000;
    else
      mute_cnt <= mute_cnt + 32'h00000001;
  end
  a_beep_start: assert property (mute_cnt <= BEEP_HALF)
    else $error("alarm without beep");
  a_beep_period: assert property (
    $rose(beeper) ##1 (beeper && high_alarm_indicator) [*3] |=> !beeper)
    else $error("beep period wrong");
  a_alarm_hold: assert property (
    $changed(high_alarm_indicator) |=> $stable(high_alarm_indicator) [*8])
    else $error("alarm changed between compares");
  a_loss_clear: assert property (
    $rose(det_pulse) |-> ##[1:3] !detector_loss_indicator)
    else $error("loss stays after pulse");
  a_irq_fall: assert property ($fell(irq) |->
    $past(pwrite && penable) || $past(pwrite && penable, 2) ||
    $past(pwrite && penable, 3))
    else $error("irq fell without write");
endmodule

bind sba_top sba_top_assertions #(.BEEP_HALF(BEEP_HALF)) u_chk (.pclk,
  .presetn, .psel, .penable,
  .pwrite, .prdata, .pready, .pslverr, .det_pulse, .high_alarm_indicator,
  .low_alarm_indicator, .beeper, .detector_loss_indicator, .irq);

// file: tb/sba_top_tb.sv
// Self-checking bench of the sigma background alarm
`timescale 1ns/1ns
// ==========================================
// Bench
module sba_top_tb import sba_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, det_pulse, hi, lo, beeper, loss, irq;
  logic [3:0] gap;
  int n_errors, comparisons;

  // Short second keeps the run small
  sba_top #(.SEC_CYCLES(64), .BEEP_HALF(4)) DUT (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .det_pulse, .high_alarm_indicator(hi),
    .low_alarm_indicator(lo), .beeper, .detector_loss_indicator(loss),
    .irq);
  sba_det_model u_det (.pclk, .presetn, .gap, .det_pulse);

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] got,
    input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      n_errors++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] x,
    input string s);
    apb(1'b0, a, 32'h0);
    chk(s, r, x);
  endtask

  task automatic wait_s(input int n);
    repeat (n * 64) @(posedge pclk);
  endtask

  task automatic t_regs();
    rdc(OFS_SIGMA, 32'h0000001E, "sigma");
    rdc(OFS_CEIL, 32'h000003E8, "ceiling");
    rdc(12'h030, 32'h0, "unmapped");
    chk("unmapped err", e, 1'b1);
    chk("low", lo, 1'b0);
    $display("t_regs done");
  endtask

  // Ceiling trips before settling, sigma stays off
  task automatic t_ceiling();
    apb(1'b1, OFS_IRQ_EN, 32'h2);
    apb(1'b1, OFS_CEIL, 32'h5);
    wait_s(3);
    rdc(OFS_STATUS, 32'h2, "status ceil");
    chk("high", hi, 1'b1);
    chk("irq", irq, 1'b1);
    apb(1'b1, OFS_CEIL, 32'h3E8);
    wait_s(2);
    rdc(OFS_STATUS, 32'h0, "status clear");
    // Latched ceiling holds after the ceiling is raised above the rate, until acknowledged
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_CEIL, 32'h5);
    wait_s(2);
    apb(1'b1, OFS_CEIL, 32'h3E8);
    wait_s(2);
    rdc(OFS_STATUS, 32'h2, "status latched");
    apb(1'b1, OFS_ACK, 32'h1);
    rdc(OFS_STATUS, 32'h0, "status acked");
    chk("high acked", hi, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_IRQ_CLR, 32'h2);
    repeat (3) @(posedge pclk);
    chk("irq clear", irq, 1'b0);
    rdc(OFS_IRQ_STAT, 32'h0, "irq stat");
    $display("t_ceiling done");
  endtask

  task automatic t_settle();
    wait_s(70);
    rdc(OFS_RATE, 32'h8, "rate");
    rdc(OFS_STATUS, 32'h8, "status settled");
    apb(1'b0, OFS_BKG, 32'h0);
    chk("bkg int", r[23:8], 16'h7);
    $display("t_settle done");
  endtask

  // Threshold 7 + s*2/10 against a steady rate of 8
  task automatic t_sigma();
    apb(1'b1, OFS_IRQ_EN, 32'h1);
    apb(1'b1, OFS_SIGMA, 32'h5);
    wait_s(2);
    rdc(OFS_STATUS, 32'h8, "at limit");
    apb(1'b1, OFS_SIGMA, 32'h4);
    wait_s(2);
    rdc(OFS_STATUS, 32'h9, "over limit");
    chk("high sigma", hi, 1'b1);
    chk("irq sigma", irq, 1'b1);
    $display("t_sigma done");
  endtask

  task automatic t_loss();
    gap <= 4'h0;
    wait_s(13);
    chk("loss early", loss, 1'b0);
    wait_s(4);
    chk("loss", loss, 1'b1);
    rdc(OFS_STATUS, 32'hC, "status loss");
    gap <= 4'h8;
    repeat (20) @(posedge pclk);
    chk("loss gone", loss, 1'b0);
    $display("t_loss done");
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    gap = 4'h8;
    n_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_ceiling();
    t_settle();
    t_sigma();
    t_loss();
    end_sim();
  end
endmodule
